// >>> design/windowed_watchdog_top.sv
// Windowed watchdog timer with APB register access
//
// Contract
// - Unfed time-out asserts chip reset
// - Feed outside window counts as failure
// - Optional warning interrupt before time-out
// - Enable set-only; cleared by reset/event
// - Bad feed sequence triggers reset or interrupt
// - Flag records watchdog-caused reset
// - 24-bit counter behind watchdog clock prescaler
// - Time-out 256x4 to 2^24x4 cycles
// - Watchdog clock selects RC or watchdog oscillator
// - Deep-sleep keeps RC only if selected
// - Watchdog interrupt wakes from low power
`timescale 1ns/1ns
module windowed_watchdog_top
  import windowed_watchdog_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        por_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        internal_rc_oscillator,
  input  wire logic        watchdog_oscillator,
  input  wire logic        deep_sleep,
  output logic             irc_keep_on,
  output logic             chip_reset,
  output logic             irq,
  output logic             wake
);
  import windowed_watchdog_pkg::*;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic                  enable;
  logic                  reset_en;
  logic                  clksel;
  logic [CNT_WIDTH-1:0]  tc;
  logic [CNT_WIDTH-1:0]  window;
  logic [WARN_WIDTH-1:0] warn;
  logic [CNT_WIDTH-1:0]  count;
  logic [ST_WIDTH-1:0]   status;
  logic [ST_WIDTH-1:0]   mask;
  logic                  rst_flag;
  logic [1:0]            prescale;
  windowed_watchdog_feed_t            feed_st;
  logic                  irc_rise;
  logic                  wdo_rise;
  logic                  watchdog_clock;
  logic                  tick;
  logic                  wr;
  logic                  rd_setup;
  logic                  feed_key1;
  logic                  valid_seq;
  logic                  feed_bad;
  logic                  win_err;
  logic                  good_feed;
  logic                  timeout;
  logic                  warn_hit;
  logic                  fault;
  logic                  wd_event;
  logic                  mapped;
  logic [ST_WIDTH-1:0]   next_status;
  logic [ST_WIDTH-1:0]   next_mask;
  logic [ST_WIDTH-1:0]   st_set;
  logic [ST_WIDTH-1:0]   st_clr;

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog clock source and prescaler
  windowed_watchdog_edge_sync u_irc_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (internal_rc_oscillator),
    .rise     (irc_rise)
  );

  windowed_watchdog_edge_sync u_wdo_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (watchdog_oscillator),
    .rise     (wdo_rise)
  );

  assign watchdog_clock = clksel ? wdo_rise : irc_rise;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prescale <= 2'h0;
    else if (!enable)
      prescale <= 2'h0;
    else if (watchdog_clock)
      prescale <= prescale + 2'h1;
  end

  assign tick = enable && watchdog_clock && (prescale == PRESCALE_LAST);

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode
  assign wr       = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;

  always_comb
  begin
    mapped = hit(paddr, OFF_MODE) || hit(paddr, OFF_TC) || hit(paddr, OFF_FEED)
          || hit(paddr, OFF_COUNT) || hit(paddr, OFF_WARN) || hit(paddr, OFF_WINDOW)
          || hit(paddr, OFF_STATUS) || hit(paddr, OFF_MASK) || hit(paddr, OFF_RSTFLAG);
  end

  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (rd_setup)
    begin
      unique case (1'b1)
        hit(paddr, OFF_MODE):    prdata <= {29'h0, clksel, reset_en, enable};
        hit(paddr, OFF_TC):      prdata <= {8'h00, tc};
        hit(paddr, OFF_COUNT):   prdata <= {8'h00, count};
        hit(paddr, OFF_WARN):    prdata <= {22'h0, warn};
        hit(paddr, OFF_WINDOW):  prdata <= {8'h00, window};
        hit(paddr, OFF_STATUS):  prdata <= {28'h0, status};
        hit(paddr, OFF_MASK):    prdata <= {28'h0, mask};
        hit(paddr, OFF_RSTFLAG): prdata <= {31'h0, rst_flag};
        default:                 prdata <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Feed sequence
  assign feed_key1 = wr && hit(paddr, OFF_FEED) && (pwdata[7:0] == FEED_KEY1);
  assign valid_seq = wr && hit(paddr, OFF_FEED) && (pwdata[7:0] == FEED_KEY2)
                  && (feed_st == FEED_ARMED);
  // Any other write after the first key breaks the sequence
  assign feed_bad  = enable && wr && (feed_st == FEED_ARMED) && !valid_seq;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      feed_st <= FEED_IDLE;
    else
    begin
      unique case (feed_st)
        FEED_IDLE:
          if (feed_key1)
            feed_st <= FEED_ARMED;
        FEED_ARMED:
          if (wr)
            feed_st <= FEED_IDLE;
      endcase
    end
  end

  assign win_err   = enable && valid_seq && (window != WINDOW_OFF) && (count > window);
  assign good_feed = valid_seq && !win_err;

  ////////////////////////////////////////////////////////////////////////////////
  // Events
  assign timeout  = tick && (count == '0);
  assign warn_hit = tick && (count == {14'h0000, warn});
  assign fault    = feed_bad || win_err;
  assign wd_event = timeout || fault;

  ////////////////////////////////////////////////////////////////////////////////
  // Mode register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable   <= MODE_RST[MODE_ENABLE];
      reset_en <= MODE_RST[MODE_RESET_EN];
      clksel   <= MODE_RST[MODE_CLKSEL];
    end
    else
    begin
      if (wd_event)
        enable <= 1'b0;
      else if (wr && hit(paddr, OFF_MODE) && pwdata[MODE_ENABLE])
        enable <= 1'b1;
      if (wr && hit(paddr, OFF_MODE))
      begin
        reset_en <= reset_en | pwdata[MODE_RESET_EN];
        if (!enable)
          clksel <= pwdata[MODE_CLKSEL];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Time-out, window and warning settings
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tc     <= TC_RST;
      window <= WINDOW_RST;
      warn   <= WARN_RST;
    end
    else if (wr)
    begin
      if (hit(paddr, OFF_TC))
        tc <= (pwdata[23:0] < TC_MIN) ? TC_MIN : pwdata[23:0];
      if (hit(paddr, OFF_WINDOW))
        window <= pwdata[23:0];
      if (hit(paddr, OFF_WARN))
        warn <= pwdata[WARN_WIDTH-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= TC_RST;
    else if (!enable)
      count <= tc;
    else if (good_feed)
      count <= tc;
    else if (tick && (count != '0))
      count <= count - 24'h000001;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Chip reset and reset flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      chip_reset <= 1'b0;
    else if (wd_event && reset_en)
      chip_reset <= 1'b1;
  end

  // Survives the chip reset; cleared by power-on or by writing 1 to bit 0
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
      rst_flag <= 1'b0;
    else if (chip_reset)
      rst_flag <= 1'b1;
    else if (wr && hit(paddr, OFF_RSTFLAG) && pwdata[0])
      rst_flag <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status and interrupt
  always_comb
  begin
    st_set = '0;
    st_set[ST_TIMEOUT]    = timeout && !reset_en;
    st_set[ST_WARN]       = warn_hit;
    st_set[ST_FEED_ERR]   = feed_bad && !reset_en;
    st_set[ST_WINDOW_ERR] = win_err && !reset_en;
    st_clr = (wr && hit(paddr, OFF_STATUS)) ? pwdata[ST_WIDTH-1:0] : '0;
    next_status = (status & ~st_clr) | st_set;
  end

  always_comb
  begin
    next_mask = mask;
    if (wr && hit(paddr, OFF_MASK))
      next_mask = pwdata[ST_WIDTH-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask <= MASK_RST;
    else
      mask <= next_mask;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status <= '0;
    else
      status <= next_status;
  end

  // Built from next state, so it moves with status and mask
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(next_status & next_mask);
  end

  assign wake = irq;

  ////////////////////////////////////////////////////////////////////////////////
  // Low-power clock keep-alive
  assign irc_keep_on = !deep_sleep || !clksel;

endmodule // windowed_watchdog_top

// >>> design/windowed_watchdog_pkg.sv
// Package: register map, field positions, reset values and timing for the windowed watchdog
package windowed_watchdog_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFF_MODE    = 8'h00;
  localparam logic [7:0] OFF_TC      = 8'h04;
  localparam logic [7:0] OFF_FEED    = 8'h08;
  localparam logic [7:0] OFF_COUNT   = 8'h0C;
  localparam logic [7:0] OFF_WARN    = 8'h10;
  localparam logic [7:0] OFF_WINDOW  = 8'h14;
  localparam logic [7:0] OFF_STATUS  = 8'h18;
  localparam logic [7:0] OFF_MASK    = 8'h1C;
  localparam logic [7:0] OFF_RSTFLAG = 8'h20;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int MODE_ENABLE   = 0;
  localparam int MODE_RESET_EN = 1;
  localparam int MODE_CLKSEL   = 2;

  localparam int ST_TIMEOUT    = 0;
  localparam int ST_WARN       = 1;
  localparam int ST_FEED_ERR   = 2;
  localparam int ST_WINDOW_ERR = 3;
  localparam int ST_WIDTH      = 4;

  localparam int CNT_WIDTH     = 24;
  localparam int WARN_WIDTH    = 10;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [2:0]           MODE_RST   = 3'h0;
  localparam logic [CNT_WIDTH-1:0] TC_RST     = 24'h0000FF;
  localparam logic [CNT_WIDTH-1:0] WINDOW_RST = 24'hFFFFFF;
  localparam logic [WARN_WIDTH-1:0] WARN_RST  = 10'h000;
  localparam logic [ST_WIDTH-1:0]  MASK_RST   = 4'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing and keys
  localparam int PRESCALE_DIV = 4;
  localparam logic [1:0] PRESCALE_LAST = 2'(PRESCALE_DIV - 1);
  localparam logic [CNT_WIDTH-1:0] TC_MIN     = 24'h0000FF;
  localparam logic [CNT_WIDTH-1:0] WINDOW_OFF = 24'hFFFFFF;
  localparam logic [7:0] FEED_KEY1 = 8'hAA;
  localparam logic [7:0] FEED_KEY2 = 8'h55;

  typedef enum logic [0:0] {
    FEED_IDLE,
    FEED_ARMED
  } windowed_watchdog_feed_t;

endpackage

// >>> design/windowed_watchdog_edge_sync.sv
// Three-stage synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ns
module windowed_watchdog_edge_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output logic      rise
);

  logic s1;
  logic s2;
  logic s3;
  logic settled;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end
    else
    begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Accept a level only once stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      settled <= 1'b0;
      rise    <= 1'b0;
    end
    else
    begin
      rise <= (s2 == s3) && s3 && !settled;
      if (s2 == s3)
        settled <= s3;
    end
  end

endmodule // windowed_watchdog_edge_sync

// >>> dv/windowed_watchdog_top_properties.sv
// Port-level checker for the windowed watchdog
`timescale 1ns/1ns
module windowed_watchdog_top_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        deep_sleep,
  input wire logic        irc_keep_on,
  input wire logic        chip_reset,
  input wire logic        irq,
  input wire logic        wake
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  sequence s_rd(logic [7:0] a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  sequence s_wr(logic [7:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence
  ////////////////////////////////////////
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_unmapped_err: assert property (psel && penable && paddr > 8'h20
    |-> pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access");
  a_feed_reads_zero: assert property (s_rd(8'h08) |-> prdata == 32'h0)
    else $error("feed read nonzero");
  a_count_width: assert property (s_rd(8'h0C) |-> prdata[31:24] == 8'h0)
    else $error("count wider than 24 bits");
  a_mask_off_quiet: assert property (s_wr(8'h1C) ##0 pwdata[3:0] == 4'h0 |=> !irq)
    else $error("irq with mask clear");
  a_wake_follows: assert property (wake == irq)
    else $error("wake differs from irq");
  a_rc_kept_awake: assert property (!deep_sleep |-> irc_keep_on)
    else $error("rc oscillator off while awake");
  a_reset_holds: assert property (chip_reset |=> chip_reset)
    else $error("chip reset dropped");
endmodule // windowed_watchdog_top_properties

bind windowed_watchdog_top windowed_watchdog_top_properties u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .deep_sleep, .irc_keep_on, .chip_reset,
  .irq, .wake);

// >>> dv/windowed_watchdog_top_tb.sv
// Testbench for the windowed watchdog
`timescale 1ns/1ns
module windowed_watchdog_top_tb;
  import windowed_watchdog_pkg::*;
  logic        pclk, presetn, por_n, psel, penable, pwrite, deep_sleep;
  logic        rc_osc = 1'b0;
  logic        wd_osc = 1'b0;
  logic        pready, pslverr, irc_keep_on, chip_reset, irq, wake, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv, c1;
  logic [2:0]  ph = 3'h0;
  logic [1:0]  q = 2'h0;
  int          error_cnt = 0, samples_checked = 0, cyc = 0;
  logic [7:0]  ra [8] = '{OFF_MODE, OFF_TC, OFF_WARN, OFF_WINDOW, OFF_STATUS, OFF_MASK,
                          OFF_RSTFLAG, OFF_COUNT};
  logic [31:0] re [8] = '{32'h0, 32'hFF, 32'h0, 32'hFFFFFF, 32'h0, 32'h0, 32'h0, 32'hFF};

  windowed_watchdog_top dut (.pclk, .presetn, .por_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .internal_rc_oscillator(rc_osc), .watchdog_oscillator(wd_osc),
    .deep_sleep, .irc_keep_on, .chip_reset, .irq, .wake);

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Oscillators: rc period 6, watchdog period 8 pclk
  always @(posedge pclk)
  begin
    ph <= ph + 3'h1;
    wd_osc <= ph[2];
    q <= (q == 2'h2) ? 2'h0 : q + 2'h1;
    if (q == 2'h2) rc_osc <= ~rc_osc;
  end

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      error_cnt++;
      end_sim;
    end
  end
  ////////////////////////////////////////
  task automatic end_sim;
    $display("Checked %0d, errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rv, e);
  endtask

  // Bounded wait for an interrupt or a chip reset
  task automatic wt(input int n);
    for (int i = 0; i < n && irq !== 1'b1 && chip_reset !== 1'b1; i++) @(posedge pclk);
  endtask
  ////////////////////////////////////////
  initial
  begin
    {presetn, por_n, psel, penable, pwrite, deep_sleep} = '0;
    {paddr, pwdata} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++) rdc(ra[i], re[i]);
    rd(8'h40);
    chk({rv[30:0], err}, 32'h1);
    rdc(OFF_FEED, 32'h0);
    wr(OFF_TC, 32'h10);
    rdc(OFF_TC, 32'hFF);
    wr(OFF_WARN, 32'h80);
    wr(OFF_MASK, 32'h2);
    wr(OFF_MODE, 32'h1);
    wr(OFF_MODE, 32'h0);
    rdc(OFF_MODE, 32'h1);
    rd(OFF_COUNT);
    c1 = rv;
    repeat (100) @(posedge pclk);
    rd(OFF_COUNT);
    chk(32'(rv < c1), 32'h1);
    wt(8000);
    rdc(OFF_STATUS, 32'h2);
    chk(32'(wake), 32'h1);
    rd(OFF_COUNT);
    chk(32'(rv <= 32'h80), 32'h1);
    wr(OFF_MASK, 32'h1);
    wt(8000);
    rdc(OFF_STATUS, 32'h3);
    rdc(OFF_MODE, 32'h0);
    wr(OFF_STATUS, 32'hF);
    chk(32'(irq), 32'h0);
    wr(OFF_MODE, 32'h1);
    wr(OFF_FEED, 32'hAA);
    wr(OFF_FEED, 32'h12);
    rdc(OFF_STATUS, 32'h4);
    rdc(OFF_MODE, 32'h0);
    wr(OFF_STATUS, 32'h4);
    wr(OFF_MODE, 32'h1);
    repeat (300) @(posedge pclk);
    rd(OFF_COUNT);
    c1 = rv;
    wr(OFF_FEED, 32'hAA);
    wr(OFF_FEED, 32'h55);
    rd(OFF_COUNT);
    chk(32'(rv > c1), 32'h1);
    wr(OFF_WINDOW, 32'h80);
    wr(OFF_FEED, 32'hAA);
    wr(OFF_FEED, 32'h55);
    rdc(OFF_STATUS, 32'h8);
    wr(OFF_STATUS, 32'h8);
    deep_sleep <= 1'b1;
    @(posedge pclk);
    chk(32'(irc_keep_on), 32'h1);
    wr(OFF_MODE, 32'h4);
    chk(32'(irc_keep_on), 32'h0);
    wr(OFF_MODE, 32'h5);
    rdc(OFF_MODE, 32'h5);
    rd(OFF_COUNT);
    c1 = rv;
    repeat (200) @(posedge pclk);
    rd(OFF_COUNT);
    // 203 edges at one tick per 32: six or seven, the RC source would give more
    chk(32'((c1 - rv) inside {32'h6, 32'h7}), 32'h1);
    deep_sleep <= 1'b0;
    wr(OFF_MASK, 32'h0);
    wr(OFF_MODE, 32'h7);
    wt(9000);
    chk(32'(chip_reset), 32'h1);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(OFF_RSTFLAG, 32'h1);
    rdc(OFF_MODE, 32'h0);
    wr(OFF_RSTFLAG, 32'h1);
    rdc(OFF_RSTFLAG, 32'h0);
    end_sim;
  end
endmodule // windowed_watchdog_top_tb
